// [rtl/socket_buffer_segment_control.sv]
`timescale 1ns/1ns
`include "socket_buffer_defines.svh"

// Summary of operation
// - segment size per socket, defaults 1460/1472/1514
// - pppoe lowers defaults to 1452 and 1464
// - tcp/udp sends split into segment-size pieces
// - icmp event sets flag, captures mtu, ip
// - flag set blocks udp transmission
// - service type register reset 00, used
// - hop limit register reset 80, used
// - receive size codes 0..16 kb, reset 2
// - illegal receive code disables reception
// - receive total above 16 kb errors
// - transmit size same coding, illegal blocks
// - transmit total above 16 kb errors
// - regions allocated in socket order
// - sixteen bit offsets address every buffer
// - free size resets 0800, tracks region
// - non-tcp free size uses read pointer
// - tcp free size uses acked pointer
// - pointers reset zero, cleared by open
// - send drains to write pointer, updates read
// - pointer arithmetic wraps modulo 65536
module socket_buffer_segment_control import socket_buffer_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] reg_socket,
    input wire logic [7:0] reg_offset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic pppoe_mode,
    input wire logic [7:0][3:0] socket_protocol_setting,
    input wire logic [7:0] open_cmd,
    input wire logic [7:0] send_cmd,
    input wire logic [7:0] connect_reinit,
    input wire logic [7:0][15:0] acked_pointer,
    input wire logic buf_write,
    input wire logic [2:0] buf_socket,
    input wire logic [15:0] buf_offset,
    input wire logic [7:0] buf_wdata,
    input wire logic icmp_frag_event,
    input wire logic [15:0] icmp_mtu,
    input wire logic [31:0] icmp_peer_ip,
    input wire logic fragment_clear,
    output logic fragment_size_event,
    output logic [15:0] reported_peer_mtu,
    output logic [31:0] unreachable_peer_ip,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic [2:0] tx_socket,
    output logic [7:0] tx_service_type,
    output logic [7:0] tx_hop_limit,
    input wire logic tx_ready,
    output logic [7:0] send_done,
    output logic [7:0] send_refused,
    output logic tx_alloc_error,
    output logic rx_alloc_error,
    output logic [7:0] rx_region_ok,
    output logic [7:0][13:0] rx_region_base
);
    logic [15:0] seg_reg [8];
    logic [7:0] service_reg [8];
    logic [7:0] hop_reg [8];
    logic [7:0] rx_size_reg [8];
    logic [7:0] tx_size_reg [8];
    ptr_t free_reg [8];
    ptr_t rd_reg [8];
    ptr_t wr_reg [8];
    logic [7:0] pending_reg;

    logic [4:0] tx_kb [8];
    logic [4:0] rx_kb [8];
    logic [7:0] tx_legal;
    logic [7:0] rx_legal;
    logic [7:0] tx_base_kb [8];
    logic [7:0] rx_base_kb [8];
    logic [7:0] tx_total;
    logic [7:0] rx_total;
    ptr_t free_next [8];

    tx_state_t state_reg;
    logic [2:0] cur_sock;
    ptr_t cur_ptr;
    ptr_t end_ptr;
    logic [15:0] cur_limit;
    logic [15:0] seg_count;
    logic pick_valid;
    logic [2:0] pick_sock;
    logic pick_blocked;
    ptr_t next_ptr;
    logic send_end;
    logic [7:0] mem_rdata;
    logic [13:0] mem_rd_addr;
    logic [13:0] mem_wr_addr;
    logic mem_wr_en;

    function automatic logic size_ok(input logic [7:0] code);
        size_ok = (code == 8'h00) || (code == 8'h01) || (code == 8'h02) || (code == 8'h04) ||
                  (code == 8'h08) || (code == 8'h10);
    endfunction

    // region base plus offset folded into the region; a zero region pins to its base
    function automatic logic [13:0] phys_addr(input logic [7:0] base_kb, input logic [4:0] kb,
                                              input ptr_t offset);
        logic [14:0] mask;
        logic [14:0] sum;
        mask = {kb, 10'h000} - 15'h0001;
        sum = {base_kb[4:0], 10'h000} + ((kb == 5'h00) ? 15'h0000 : (offset[14:0] & mask));
        phys_addr = sum[13:0];
    endfunction

    function automatic logic [15:0] seg_limit(input logic [3:0] proto, input logic [15:0] size,
                                              input logic pppoe);
        logic [15:0] dflt;
        dflt = `MTU_TCP;
        if (proto == `PROTO_RAW) begin
            dflt = `MTU_RAW;
        end else if (proto == `PROTO_UDP) begin
            dflt = pppoe ? `MTU_UDP_PPPOE : `MTU_UDP;
        end else begin
            dflt = pppoe ? `MTU_TCP_PPPOE : `MTU_TCP;
        end
        // raw mode never uses the programmed size: it always splits at the 1514-byte raw default
        if (proto == `PROTO_RAW || size == 16'h0000 || size > dflt) begin
            seg_limit = dflt;
        end else begin
            seg_limit = size;
        end
    endfunction

    always_comb begin
        logic [7:0] acc_tx;
        logic [7:0] acc_rx;
        ptr_t used;
        acc_tx = 8'h00;
        acc_rx = 8'h00;
        used = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            tx_legal[i] = size_ok(tx_size_reg[i]);
            rx_legal[i] = size_ok(rx_size_reg[i]);
            tx_kb[i] = tx_legal[i] ? tx_size_reg[i][4:0] : 5'h00;
            rx_kb[i] = rx_legal[i] ? rx_size_reg[i][4:0] : 5'h00;
            tx_base_kb[i] = acc_tx;
            rx_base_kb[i] = acc_rx;
            acc_tx = acc_tx + {3'h0, tx_kb[i]};
            acc_rx = acc_rx + {3'h0, rx_kb[i]};
            if (socket_protocol_setting[i] == `PROTO_TCP) begin
                used = wr_reg[i] - acked_pointer[i];
            end else begin
                used = wr_reg[i] - rd_reg[i];
            end
            free_next[i] = {1'b0, tx_kb[i], 10'h000} - used;
        end
        tx_total = acc_tx;
        rx_total = acc_rx;
    end

    always_comb begin
        pick_valid = 1'b0;
        pick_sock = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pending_reg[i]) begin
                pick_valid = 1'b1;
                pick_sock = 3'(i);
            end
        end
        pick_blocked = !tx_legal[pick_sock] || (tx_total > `MEM_KB) ||
                       (fragment_size_event && socket_protocol_setting[pick_sock] == `PROTO_UDP);
    end

    assign next_ptr = cur_ptr + 16'h0001;
    assign send_end = (next_ptr == end_ptr);
    assign mem_rd_addr = phys_addr(tx_base_kb[cur_sock], tx_kb[cur_sock], cur_ptr);
    assign mem_wr_addr = phys_addr(tx_base_kb[buf_socket], tx_kb[buf_socket], buf_offset);
    // writes into a broken layout are dropped rather than corrupting a neighbour
    assign mem_wr_en = buf_write && tx_legal[buf_socket] && (tx_total <= `MEM_KB);

    tx_byte_memory tx_mem (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(buf_wdata),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rdata)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                seg_reg[i] <= `RST_SEG;
                service_reg[i] <= `RST_SERVICE;
                hop_reg[i] <= `RST_HOP;
                rx_size_reg[i] <= `RST_REGION;
                tx_size_reg[i] <= `RST_REGION;
            end
        end else if (reg_write) begin
            if (reg_offset == `OFS_SEG_HI) begin
                seg_reg[reg_socket][15:8] <= reg_wdata;
            end else if (reg_offset == `OFS_SEG_LO) begin
                seg_reg[reg_socket][7:0] <= reg_wdata;
            end else if (reg_offset == `OFS_SERVICE) begin
                service_reg[reg_socket] <= reg_wdata;
            end else if (reg_offset == `OFS_HOP) begin
                hop_reg[reg_socket] <= reg_wdata;
            end else if (reg_offset == `OFS_RX_SIZE) begin
                rx_size_reg[reg_socket] <= reg_wdata;
            end else if (reg_offset == `OFS_TX_SIZE) begin
                tx_size_reg[reg_socket] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                free_reg[i] <= `RST_FREE;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                free_reg[i] <= free_next[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                wr_reg[i] <= `RST_PTR;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (open_cmd[i] || (connect_reinit[i] && socket_protocol_setting[i] == `PROTO_TCP)) begin
                    wr_reg[i] <= `RST_PTR;
                end else if (reg_write && reg_socket == 3'(i) && reg_offset == `OFS_WR_HI) begin
                    wr_reg[i][15:8] <= reg_wdata;
                end else if (reg_write && reg_socket == 3'(i) && reg_offset == `OFS_WR_LO) begin
                    wr_reg[i][7:0] <= reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                rd_reg[i] <= `RST_PTR;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (open_cmd[i] || (connect_reinit[i] && socket_protocol_setting[i] == `PROTO_TCP)) begin
                    rd_reg[i] <= `RST_PTR;
                end else if (state_reg == ST_SHOW && tx_ready && send_end && cur_sock == 3'(i)) begin
                    rd_reg[i] <= end_ptr;
                end
            end
        end
    end

    // a send that lands while its socket is being picked stays queued
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pending_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (send_cmd[i]) begin
                    pending_reg[i] <= 1'b1;
                end else if (open_cmd[i] || (state_reg == ST_IDLE && pick_valid && pick_sock == 3'(i))) begin
                    pending_reg[i] <= 1'b0;
                end
            end
        end
    end

    // at most one byte every three cycles, more while tx_ready stalls: simple, and the link side is far slower anyway
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            cur_sock <= 3'h0;
            cur_ptr <= `RST_PTR;
            end_ptr <= `RST_PTR;
            cur_limit <= `MTU_TCP;
            seg_count <= 16'h0001;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            tx_socket <= 3'h0;
            tx_service_type <= `RST_SERVICE;
            tx_hop_limit <= `RST_HOP;
            send_done <= 8'h00;
            send_refused <= 8'h00;
        end else begin
            send_done <= 8'h00;
            send_refused <= 8'h00;
            case (state_reg)
                ST_IDLE: begin
                    if (pick_valid) begin
                        if (pick_blocked) begin
                            send_refused[pick_sock] <= 1'b1;
                        end else if (rd_reg[pick_sock] == wr_reg[pick_sock]) begin
                            send_done[pick_sock] <= 1'b1;
                        end else begin
                            cur_sock <= pick_sock;
                            cur_ptr <= rd_reg[pick_sock];
                            end_ptr <= wr_reg[pick_sock];
                            cur_limit <= seg_limit(socket_protocol_setting[pick_sock], seg_reg[pick_sock],
                                                   pppoe_mode);
                            seg_count <= 16'h0001;
                            tx_socket <= pick_sock;
                            tx_service_type <= service_reg[pick_sock];
                            tx_hop_limit <= hop_reg[pick_sock];
                            state_reg <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    state_reg <= ST_LOAD;
                end
                ST_LOAD: begin
                    tx_data <= mem_rdata;
                    tx_valid <= 1'b1;
                    tx_last <= send_end || (seg_count == cur_limit);
                    state_reg <= ST_SHOW;
                end
                ST_SHOW: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        tx_last <= 1'b0;
                        cur_ptr <= next_ptr;
                        seg_count <= (seg_count == cur_limit) ? 16'h0001 : seg_count + 16'h0001;
                        if (send_end) begin
                            send_done[cur_sock] <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_FETCH;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // a fresh report in the same cycle as a clear keeps the flag up
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fragment_size_event <= 1'b0;
            reported_peer_mtu <= 16'h0000;
            unreachable_peer_ip <= 32'h00000000;
        end else if (icmp_frag_event) begin
            fragment_size_event <= 1'b1;
            reported_peer_mtu <= icmp_mtu;
            unreachable_peer_ip <= icmp_peer_ip;
        end else if (fragment_clear) begin
            fragment_size_event <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_alloc_error <= 1'b0;
            rx_alloc_error <= 1'b0;
            rx_region_ok <= 8'h00;
            rx_region_base <= '0;
        end else begin
            tx_alloc_error <= (tx_total > `MEM_KB);
            rx_alloc_error <= (rx_total > `MEM_KB);
            for (int i = 0; i < 8; i++) begin
                rx_region_ok[i] <= rx_legal[i] && (rx_total <= `MEM_KB);
                rx_region_base[i] <= {rx_base_kb[i][3:0], 10'h000};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rvalid <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_offset == `OFS_SEG_HI) begin
                reg_rdata <= seg_reg[reg_socket][15:8];
            end else if (reg_offset == `OFS_SEG_LO) begin
                reg_rdata <= seg_reg[reg_socket][7:0];
            end else if (reg_offset == `OFS_SERVICE) begin
                reg_rdata <= service_reg[reg_socket];
            end else if (reg_offset == `OFS_HOP) begin
                reg_rdata <= hop_reg[reg_socket];
            end else if (reg_offset == `OFS_RX_SIZE) begin
                reg_rdata <= rx_size_reg[reg_socket];
            end else if (reg_offset == `OFS_TX_SIZE) begin
                reg_rdata <= tx_size_reg[reg_socket];
            end else if (reg_offset == `OFS_FREE_HI) begin
                reg_rdata <= free_reg[reg_socket][15:8];
            end else if (reg_offset == `OFS_FREE_LO) begin
                reg_rdata <= free_reg[reg_socket][7:0];
            end else if (reg_offset == `OFS_RD_HI) begin
                reg_rdata <= rd_reg[reg_socket][15:8];
            end else if (reg_offset == `OFS_RD_LO) begin
                reg_rdata <= rd_reg[reg_socket][7:0];
            end else if (reg_offset == `OFS_WR_HI) begin
                reg_rdata <= wr_reg[reg_socket][15:8];
            end else if (reg_offset == `OFS_WR_LO) begin
                reg_rdata <= wr_reg[reg_socket][7:0];
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    free_reset_a: assert property (@(posedge core_clk) $fell(reset) |-> free_reg[0] == `RST_FREE)
        else $error("free size not 0800 after reset");
    free_calc_a: assert property (@(posedge core_clk) disable iff (reset)
        socket_protocol_setting[0] == `PROTO_UDP && $stable(wr_reg[0]) && $stable(rd_reg[0]) && $stable(tx_kb[0])
        |=> free_reg[0] == {1'b0, $past(tx_kb[0]), 10'h000} - ($past(wr_reg[0]) - $past(rd_reg[0])))
        else $error("udp free size wrong");
    seg_last_a: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && seg_count == cur_limit |-> tx_last)
        else $error("segment longer than limit");
    seg_bound_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg != ST_IDLE |-> seg_count >= 16'h0001 && seg_count <= cur_limit)
        else $error("segment count out of range");
    tcp_default_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == ST_IDLE && pick_valid && !pick_blocked && rd_reg[pick_sock] != wr_reg[pick_sock] &&
        socket_protocol_setting[pick_sock] == `PROTO_TCP && seg_reg[pick_sock] == 16'h0000 && !pppoe_mode
        |=> cur_limit == `MTU_TCP)
        else $error("tcp default segment size wrong");
    pppoe_udp_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == ST_IDLE && pick_valid && !pick_blocked && rd_reg[pick_sock] != wr_reg[pick_sock] &&
        socket_protocol_setting[pick_sock] == `PROTO_UDP && seg_reg[pick_sock] > `MTU_UDP_PPPOE && pppoe_mode
        |=> cur_limit == `MTU_UDP_PPPOE)
        else $error("pppoe udp limit wrong");
    frag_capture_a: assert property (@(posedge core_clk) disable iff (reset)
        icmp_frag_event |=> fragment_size_event && reported_peer_mtu == $past(icmp_mtu))
        else $error("fragment report not captured");
    frag_block_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == ST_IDLE && pick_valid && fragment_size_event &&
        socket_protocol_setting[pick_sock] == `PROTO_UDP |=> state_reg == ST_IDLE && send_refused != 8'h00)
        else $error("udp send not refused under fragment flag");
    send_drain_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == ST_SHOW && tx_ready && send_end && !open_cmd[cur_sock] && !connect_reinit[cur_sock]
        |=> rd_reg[$past(cur_sock)] == $past(end_ptr) && send_done != 8'h00 && state_reg == ST_IDLE)
        else $error("read pointer not moved to write pointer");
    ptr_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == ST_SHOW && tx_ready && cur_ptr == 16'hFFFF |=> cur_ptr == 16'h0000)
        else $error("pointer did not wrap");
    open_init_a: assert property (@(posedge core_clk) disable iff (reset)
        open_cmd[0] |=> rd_reg[0] == `RST_PTR && wr_reg[0] == `RST_PTR)
        else $error("open did not clear pointers");
    alloc_err_a: assert property (@(posedge core_clk) disable iff (reset)
        tx_total > `MEM_KB |=> tx_alloc_error)
        else $error("transmit overallocation not flagged");

    send_seen_c: cover property (@(posedge core_clk) disable iff (reset) send_done != 8'h00);
    split_seen_c: cover property (@(posedge core_clk) disable iff (reset) tx_valid && tx_last && !send_end);
    refuse_seen_c: cover property (@(posedge core_clk) disable iff (reset) send_refused != 8'h00);
    wrap_seen_c: cover property (@(posedge core_clk) disable iff (reset) state_reg == ST_SHOW && cur_ptr == 16'hFFFF);
endmodule

// [rtl/socket_buffer_defines.svh]
`ifndef SOCKET_BUFFER_DEFINES_SVH
`define SOCKET_BUFFER_DEFINES_SVH

`define OFS_SEG_HI 8'h12
`define OFS_SEG_LO 8'h13
`define OFS_SERVICE 8'h15
`define OFS_HOP 8'h16
`define OFS_RX_SIZE 8'h1E
`define OFS_TX_SIZE 8'h1F
`define OFS_FREE_HI 8'h20
`define OFS_FREE_LO 8'h21
`define OFS_RD_HI 8'h22
`define OFS_RD_LO 8'h23
`define OFS_WR_HI 8'h24
`define OFS_WR_LO 8'h25

`define RST_SEG 16'h0000
`define RST_SERVICE 8'h00
`define RST_HOP 8'h80
`define RST_REGION 8'h02
`define RST_FREE 16'h0800
`define RST_PTR 16'h0000

`define MTU_TCP 16'h05B4
`define MTU_UDP 16'h05C0
`define MTU_RAW 16'h05EA
`define MTU_TCP_PPPOE 16'h05AC
`define MTU_UDP_PPPOE 16'h05B8

`define PROTO_TCP 4'h1
`define PROTO_UDP 4'h2
`define PROTO_RAW 4'h4

`define MEM_KB 8'h10
`define MEM_AW 14

`endif

// [rtl/socket_buffer_pkg.sv]
package socket_buffer_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_LOAD = 4'h4,
        ST_SHOW = 4'h8
    } tx_state_t;

    typedef logic [15:0] ptr_t;

endpackage

// [rtl/tx_byte_memory.sv]
`timescale 1ns/1ns
`include "socket_buffer_defines.svh"

module tx_byte_memory (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [`MEM_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [`MEM_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:(1<<`MEM_AW)-1];

    // array left without reset so it maps onto block ram
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// [tb/tx_sink.sv]
`timescale 1ns/1ns
module tx_sink (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic [15:0] n_bytes,
    output logic [15:0] n_last,
    output logic [7:0] last_data
);
    // stalls every other cycle so the held outputs are exercised
    always_ff @(posedge core_clk) begin
        tx_ready <= reset ? 1'b0 : ~tx_ready;
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            n_bytes <= 16'h0000;
            n_last <= 16'h0000;
        end else if (tx_valid && tx_ready) begin
            n_bytes <= n_bytes + 16'h0001;
            n_last <= n_last + {15'h0000, tx_last};
            last_data <= tx_data;
        end
    end
endmodule

// [tb/tb_socket_buffer_segment_control.sv]
`timescale 1ns/1ns
module tb_socket_buffer_segment_control;
    logic core_clk = 0, reset = 1, reg_write = 0, reg_read = 0, pppoe_mode = 0, buf_write = 0, tx_ready;
    logic icmp_frag_event = 0, fragment_clear = 0, reg_rvalid, fragment_size_event, tx_valid, tx_last;
    logic tx_alloc_error, rx_alloc_error;
    logic [2:0] reg_socket = 0, buf_socket = 0, tx_socket;
    logic [7:0] reg_offset = 0, reg_wdata = 0, open_cmd = 0, send_cmd = 0, connect_reinit = 0, buf_wdata = 0;
    logic [7:0] reg_rdata, tx_data, tx_service_type, tx_hop_limit, send_done, send_refused, rx_region_ok, last_data;
    logic [7:0][3:0] socket_protocol_setting = {8{4'h2}};
    logic [7:0][15:0] acked_pointer = '0;
    logic [7:0][13:0] rx_region_base;
    logic [15:0] buf_offset = 0, icmp_mtu = 16'h0400, reported_peer_mtu, n_bytes, n_last;
    logic [31:0] icmp_peer_ip = 32'h0A000001, unreachable_peer_ip;
    logic [7:0] ofs_tbl [10] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h24};
    logic [7:0] rst_tbl [10] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h02, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00};
    int failures = 0, n_compared = 0, cyc = 0;
    socket_buffer_segment_control i_socket_buffer_segment_control (.core_clk, .reset, .reg_socket, .reg_offset,
        .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid, .pppoe_mode, .socket_protocol_setting,
        .open_cmd, .send_cmd, .connect_reinit, .acked_pointer, .buf_write, .buf_socket, .buf_offset, .buf_wdata,
        .icmp_frag_event, .icmp_mtu, .icmp_peer_ip, .fragment_clear, .fragment_size_event, .reported_peer_mtu,
        .unreachable_peer_ip, .tx_valid, .tx_data, .tx_last, .tx_socket, .tx_service_type, .tx_hop_limit,
        .tx_ready, .send_done, .send_refused, .tx_alloc_error, .rx_alloc_error, .rx_region_ok, .rx_region_base);
    tx_sink i_tx_sink (.core_clk, .reset, .tx_valid, .tx_data, .tx_last, .tx_ready, .n_bytes, .n_last, .last_data);
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(logic [7:0] ofs, logic [7:0] exp);
        reg_offset = ofs;
        reg_read = 1'b1;
        @(posedge core_clk) #1;
        check("rvalid", reg_rvalid, 1'b1);
        check($sformatf("reg %h", ofs), reg_rdata, exp);
        reg_read = 1'b0;
        @(posedge core_clk) #1;
    endtask
    task automatic wr(logic [7:0] ofs, logic [7:0] d);
        reg_offset = ofs;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge core_clk) #1;
        reg_write = 1'b0;
        @(posedge core_clk) #1;
    endtask
    initial forever #20 core_clk = ~core_clk;
    // ceiling well above the roughly 110 cycles the sequence needs
    always @(posedge core_clk) if (++cyc > 3000) begin
        failures++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        #1 reset = 0;
        foreach (ofs_tbl[i]) rd_chk(ofs_tbl[i], rst_tbl[i]);
        wr(8'h22, 8'h55);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h30, 8'h00);
        $display("test registers done");
        wr(8'h15, 8'h5A);
        wr(8'h13, 8'h02);
        rd_chk(8'h20, 8'h08);
        for (int i = 0; i < 3; i++) begin
            buf_offset = 16'(i);
            buf_wdata = 8'hA0 + 8'(i);
            buf_write = 1'b1;
            @(posedge core_clk) #1;
            buf_write = 1'b0;
            @(posedge core_clk) #1;
        end
        wr(8'h25, 8'h03);
        rd_chk(8'h21, 8'hFD);
        send_cmd[0] = 1'b1;
        @(posedge core_clk) #1;
        send_cmd[0] = 1'b0;
        repeat (200) if (send_done[0] !== 1'b1) @(posedge core_clk) #1;
        check("send_done", send_done[0], 1'b1);
        check("bytes", n_bytes, 16'h0003);
        check("segments", n_last, 16'h0002);
        check("last byte", last_data, 8'hA2);
        check("service", tx_service_type, 8'h5A);
        check("hop", tx_hop_limit, 8'h80);
        rd_chk(8'h23, 8'h03);
        rd_chk(8'h20, 8'h08);
        open_cmd[0] = 1'b1;
        @(posedge core_clk) #1;
        open_cmd[0] = 1'b0;
        rd_chk(8'h25, 8'h00);
        $display("test send done");
        icmp_frag_event = 1'b1;
        @(posedge core_clk) #1;
        icmp_frag_event = 1'b0;
        check("frag flag", fragment_size_event, 1'b1);
        check("frag mtu", reported_peer_mtu, 16'h0400);
        check("frag ip", unreachable_peer_ip[15:0], 16'h0001);
        send_cmd[0] = 1'b1;
        @(posedge core_clk) #1;
        send_cmd[0] = 1'b0;
        repeat (50) if (send_refused[0] !== 1'b1) @(posedge core_clk) #1;
        check("refused", send_refused[0], 1'b1);
        fragment_clear = 1'b1;
        @(posedge core_clk) #1;
        fragment_clear = 1'b0;
        check("frag clear", fragment_size_event, 1'b0);
        wr(8'h12, reported_peer_mtu[15:8]);
        wr(8'h13, reported_peer_mtu[7:0]);
        open_cmd[0] = 1'b1;
        @(posedge core_clk) #1;
        open_cmd[0] = 1'b0;
        rd_chk(8'h12, 8'h04);
        $display("test fragment done");
        reg_socket = 3'h1;
        socket_protocol_setting[1] = 4'h1;
        acked_pointer[1] = 16'h0001;
        wr(8'h25, 8'h05);
        rd_chk(8'h21, 8'hFC);
        send_cmd[1] = 1'b1;
        @(posedge core_clk) #1;
        send_cmd[1] = 1'b0;
        repeat (200) if (send_done[1] !== 1'b1) @(posedge core_clk) #1;
        check("tcp bytes", n_bytes, 16'h0008);
        check("tcp segments", n_last, 16'h0003);
        check("socket", tx_socket, 3'h1);
        connect_reinit[1] = 1'b1;
        @(posedge core_clk) #1;
        connect_reinit[1] = 1'b0;
        rd_chk(8'h25, 8'h00);
        reg_socket = 3'h0;
        check("rx base", rx_region_base[1], 14'h0800);
        wr(8'h1E, 8'h03);
        check("rx ok", rx_region_ok, 8'hFE);
        check("rx base 0", rx_region_base[1], 14'h0000);
        wr(8'h1E, 8'h10);
        check("rx err", rx_alloc_error, 1'b1);
        wr(8'h1F, 8'h10);
        check("tx err", tx_alloc_error, 1'b1);
        $display("test tcp and layout done");
        wrap_up;
    end
endmodule
